// ==== tcw_pkg.sv ====
// constants and types for the 8-bit compare waveform timer
package tcw_pkg;
   // counter geometry
   localparam int unsigned CNT_W        = 8;
   localparam logic [7:0]  COUNT_MAX    = 8'hFF;
   localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
   localparam logic [7:0]  COUNT_STEP   = 8'h01;

   // waveform modes
   localparam logic [2:0]  MODE_NORMAL   = 3'h0;
   localparam logic [2:0]  MODE_CLEAR    = 3'h2;
   localparam logic [2:0]  MODE_FAST_MAX = 3'h3;
   localparam logic [2:0]  MODE_FAST_CMP = 3'h7;
   localparam int unsigned MODE_PWM_BIT  = 0;
   localparam int unsigned MODE_BIT2     = 2;

   // output action codes
   localparam logic [1:0]  ACT_OFF    = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE = 2'h1;
   localparam logic [1:0]  ACT_CLEAR  = 2'h2;
   localparam logic [1:0]  ACT_SET    = 2'h3;

   // register byte offsets
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_FORCE  = 8'h04;
   localparam logic [7:0]  REG_COUNT  = 8'h08;
   localparam logic [7:0]  REG_CMP_A  = 8'h0C;
   localparam logic [7:0]  REG_CMP_B  = 8'h10;
   localparam logic [7:0]  REG_FLAGS  = 8'h14;
   localparam logic [7:0]  REG_STATUS = 8'h18;

   // field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_ACT_B_LSB = 4;
   localparam int unsigned CTRL_ACT_A_LSB = 6;
   localparam int unsigned FORCE_A_BIT    = 0;
   localparam int unsigned FORCE_B_BIT    = 1;
   localparam int unsigned FLAG_OVF_BIT   = 0;
   localparam int unsigned FLAG_CMPA_BIT  = 1;
   localparam int unsigned FLAG_CMPB_BIT  = 2;
   localparam int unsigned STAT_WAVEA_BIT = 0;
   localparam int unsigned STAT_WAVEB_BIT = 1;
   localparam int unsigned STAT_BLOCK_BIT = 2;

   // bus encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam int unsigned HTRANS_ACT_BIT = 1;
   localparam logic        HRESP_OKAY    = 1'b0;
   localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

   typedef struct packed {
      logic [1:0] output_action_a;
      logic [1:0] output_action_b;
      logic [2:0] waveform_mode_sel;
   } tcw_ctrl_t;

   typedef struct packed {
      logic port_data;
      logic port_dir;
   } tcw_pin_t;

   typedef struct packed {
      logic pin_out;
      logic pin_oe;
   } tcw_pad_t;
endpackage : tcw_pkg

// ==== tcw_timer.sv ====
// 8-bit timer with two compare waveform outputs and AHB-Lite registers
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Function
// - count write blocks matches next timer cycle
// - mode change keeps output states
// - output action applies immediately, unbuffered
// - reset clears output states to zero
// - nonzero action overrides port data, direction kept
// - action zero leaves output state unchanged
// - force strobe applies action in non-PWM
// - only mode selects counting sequence
// - mode 0 counts up, wraps FF to 00
// - normal overflow flag sets as counter hits zero
// - mode 2 clears counter on compare A
// - compare A below count wraps first
// - clear mode action one toggles A
// - clear mode overflow on max to zero
// - modes 3 and 7 single-slope to top
// - fast PWM two clears/sets, three inverse
// - fast PWM counter clears after top
// - fast PWM overflow flag at top
// - fast PWM toggle only A with bit2
// - fast PWM buffers compare, clear mode direct
// - compare zero spike, compare max constant
// - compare flag set after match, cleared externally
// - forced match sets no flag, no counter change
// - buffered writes copied to active at top
module tcw_timer
   import tcw_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // timer clock enable from prescaler
   input  wire logic        tick_en,
   // flag clear on interrupt service
   input  wire logic [2:0]  service_ack,
   // port pin logic
   input  wire tcw_pin_t    port_a,
   input  wire tcw_pin_t    port_b,
   output tcw_pad_t         pad_a,
   output tcw_pad_t         pad_b,
   // event flags
   output logic             overflow_flag,
   output logic             compare_flag_a,
   output logic             compare_flag_b
);

   // next output state for one channel
   function automatic logic wave_fn(
      input logic       cur,
      input logic [1:0] act,
      input logic       pwm,
      input logic       fast,
      input logic       tog_ok,
      input logic       match,
      input logic       force_i,
      input logic       top_tick
   );
      logic r;
      r = cur;
      if (!pwm)
      begin
         if (match || force_i)
         begin
            unique case (act)
               ACT_OFF:    r = cur;
               ACT_TOGGLE: r = ~cur;
               ACT_CLEAR:  r = 1'b0;
               ACT_SET:    r = 1'b1;
            endcase
         end
      end
      else if (fast)
      begin
         // restart action wins so compare at top gives a steady level
         if (top_tick && act[1])
            r = (act == ACT_CLEAR);
         else if (match)
         begin
            unique case (act)
               ACT_OFF:    r = cur;
               ACT_TOGGLE: r = tog_ok ? ~cur : cur;
               ACT_CLEAR:  r = 1'b0;
               ACT_SET:    r = 1'b1;
            endcase
         end
      end
      return r;
   endfunction : wave_fn

   // pin source select
   function automatic logic pin_fn(
      input logic [1:0] act,
      input logic       wave,
      input logic       pdata
   );
      return (act != ACT_OFF) ? wave : pdata;
   endfunction : pin_fn

   // write select for one register offset, data phase only
   function automatic logic wr_sel_fn(
      input logic       pend,
      input logic [7:0] addr,
      input logic [7:0] reg_off
   );
      return pend && (addr == reg_off);
   endfunction : wr_sel_fn

   // compare hit on a live timer tick unless a count write blocks it
   function automatic logic match_fn(
      input logic       tick,
      input logic       blocked,
      input logic [7:0] cnt,
      input logic [7:0] cmp
   );
      return tick && !blocked && (cnt == cmp);
   endfunction : match_fn

   // flag clear by a one written to its bit or by service acknowledge
   function automatic logic clr_fn(
      input logic        wr,
      input logic [31:0] data,
      input logic [2:0]  ack,
      input int unsigned pos
   );
      return (wr && data[pos]) || ack[pos];
   endfunction : clr_fn

   // registers
   tcw_ctrl_t   ctrl_reg;
   logic [7:0]  count_value_reg;
   logic [7:0]  cmp_a_buf_reg;
   logic [7:0]  cmp_b_buf_reg;
   logic [7:0]  compare_reg_a;
   logic [7:0]  compare_reg_b;
   logic        block_reg;
   logic        wave_a_reg;
   logic        wave_b_reg;
   logic        ovf_reg;
   logic        cfa_reg;
   logic        cfb_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] hrdata_reg;
   tcw_pad_t    pad_a_reg;
   tcw_pad_t    pad_b_reg;

   // bus decode
   wire         addr_ok  = hsel && hready && htrans[HTRANS_ACT_BIT];
   wire [7:0]   rd_addr  = haddr[7:0];
   wire         wr_ctrl  = wr_sel_fn(wr_pend_reg, wr_addr_reg, REG_CTRL);
   wire         wr_force = wr_sel_fn(wr_pend_reg, wr_addr_reg, REG_FORCE);
   wire         wr_cnt   = wr_sel_fn(wr_pend_reg, wr_addr_reg, REG_COUNT);
   wire         wr_cmpa  = wr_sel_fn(wr_pend_reg, wr_addr_reg, REG_CMP_A);
   wire         wr_cmpb  = wr_sel_fn(wr_pend_reg, wr_addr_reg, REG_CMP_B);
   wire         wr_flags = wr_sel_fn(wr_pend_reg, wr_addr_reg, REG_FLAGS);
   wire [7:0]   wdat     = hwdata[7:0];

   // mode decode: counting depends on mode only
   wire [2:0]   mode     = ctrl_reg.waveform_mode_sel;
   wire         is_pwm   = mode[MODE_PWM_BIT];
   wire         is_fast  = (mode == MODE_FAST_MAX) || (mode == MODE_FAST_CMP);
   wire         is_clear = (mode == MODE_CLEAR);
   wire [7:0]   top_val  = (mode == MODE_FAST_CMP) ? compare_reg_a : COUNT_MAX;

   // counter events
   wire         at_top   = (count_value_reg == top_val);
   wire         at_max   = (count_value_reg == COUNT_MAX);
   wire         step     = tick_en && !wr_cnt;
   wire         match_a  = match_fn(tick_en, block_reg, count_value_reg, compare_reg_a);
   wire         match_b  = match_fn(tick_en, block_reg, count_value_reg, compare_reg_b);
   wire         top_tick = step && is_fast && at_top;
   wire         restart  = top_tick || (is_clear && match_a);
   wire [7:0]   cnt_inc  = count_value_reg + COUNT_STEP;

   // overflow: at top in fast mode, at max otherwise
   wire         ovf_set  = step && (is_fast ? at_top : at_max);

   // force strobes only act outside PWM
   wire         force_a  = wr_force && hwdata[FORCE_A_BIT] && !is_pwm;
   wire         force_b  = wr_force && hwdata[FORCE_B_BIT] && !is_pwm;

   // flag clears: write one or service acknowledge
   wire         clr_ovf  = clr_fn(wr_flags, hwdata, service_ack, FLAG_OVF_BIT);
   wire         clr_cfa  = clr_fn(wr_flags, hwdata, service_ack, FLAG_CMPA_BIT);
   wire         clr_cfb  = clr_fn(wr_flags, hwdata, service_ack, FLAG_CMPB_BIT);

   // next values
   logic [7:0]  count_next;
   logic        block_next;
   logic [7:0]  cmp_a_next;
   logic [7:0]  cmp_b_next;
   logic        wave_a_next;
   logic        wave_b_next;
   logic [31:0] rd_word;

   // software write overrides count and clear
   assign count_next = wr_cnt  ? wdat
                     : !step   ? count_value_reg
                     : restart ? COUNT_BOTTOM
                     : cnt_inc;

   // block lasts until the next timer clock, even when stopped
   assign block_next = wr_cnt ? 1'b1 : (tick_en ? 1'b0 : block_reg);

   // direct update outside fast PWM, copy at top inside it
   assign cmp_a_next = (wr_cmpa && !is_fast) ? wdat
                     : top_tick              ? cmp_a_buf_reg
                     : compare_reg_a;
   assign cmp_b_next = (wr_cmpb && !is_fast) ? wdat
                     : top_tick              ? cmp_b_buf_reg
                     : compare_reg_b;

   // action bits read live, never buffered; forced matches skip flags
   assign wave_a_next = wave_fn(wave_a_reg, ctrl_reg.output_action_a, is_pwm, is_fast,
                                mode[MODE_BIT2], match_a, force_a,
                                top_tick);
   assign wave_b_next = wave_fn(wave_b_reg, ctrl_reg.output_action_b, is_pwm, is_fast,
                                1'b0, match_b, force_b, top_tick);

   // read mux, sampled in the address phase
   always_comb
   begin
      rd_word = WORD_ZERO;
      unique case (rd_addr)
         REG_CTRL:
         begin
            rd_word[CTRL_MODE_LSB +: 3]  = ctrl_reg.waveform_mode_sel;
            rd_word[CTRL_ACT_B_LSB +: 2] = ctrl_reg.output_action_b;
            rd_word[CTRL_ACT_A_LSB +: 2] = ctrl_reg.output_action_a;
         end
         REG_COUNT: rd_word[7:0] = count_value_reg;
         REG_CMP_A: rd_word[7:0] = cmp_a_buf_reg;
         REG_CMP_B: rd_word[7:0] = cmp_b_buf_reg;
         REG_FLAGS:
         begin
            rd_word[FLAG_OVF_BIT]  = ovf_reg;
            rd_word[FLAG_CMPA_BIT] = cfa_reg;
            rd_word[FLAG_CMPB_BIT] = cfb_reg;
         end
         REG_STATUS:
         begin
            rd_word[STAT_WAVEA_BIT] = wave_a_reg;
            rd_word[STAT_WAVEB_BIT] = wave_b_reg;
            rd_word[STAT_BLOCK_BIT] = block_reg;
         end
         default: rd_word = WORD_ZERO;
      endcase
   end

   // bus slave: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= REG_CTRL;
         hrdata_reg  <= WORD_ZERO;
      end
      else
      begin
         wr_pend_reg <= addr_ok && hwrite;
         wr_addr_reg <= rd_addr;
         hrdata_reg  <= (addr_ok && !hwrite) ? rd_word : hrdata_reg;
      end
   end

   // control and compare buffers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg      <= '0;
         cmp_a_buf_reg <= COUNT_BOTTOM;
         cmp_b_buf_reg <= COUNT_BOTTOM;
         compare_reg_a <= COUNT_BOTTOM;
         compare_reg_b <= COUNT_BOTTOM;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_reg.waveform_mode_sel <= hwdata[CTRL_MODE_LSB +: 3];
            ctrl_reg.output_action_b   <= hwdata[CTRL_ACT_B_LSB +: 2];
            ctrl_reg.output_action_a   <= hwdata[CTRL_ACT_A_LSB +: 2];
         end
         cmp_a_buf_reg <= wr_cmpa ? wdat : cmp_a_buf_reg;
         cmp_b_buf_reg <= wr_cmpb ? wdat : cmp_b_buf_reg;
         compare_reg_a <= cmp_a_next;
         compare_reg_b <= cmp_b_next;
      end
   end

   // counter and output states; mode writes never touch the states
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         count_value_reg <= COUNT_BOTTOM;
         block_reg       <= 1'b0;
         wave_a_reg      <= 1'b0;
         wave_b_reg      <= 1'b0;
      end
      else
      begin
         count_value_reg <= count_next;
         block_reg       <= block_next;
         wave_a_reg      <= wave_a_next;
         wave_b_reg      <= wave_b_next;
      end
   end

   // sticky flags, set wins over clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ovf_reg <= 1'b0;
         cfa_reg <= 1'b0;
         cfb_reg <= 1'b0;
      end
      else
      begin
         ovf_reg <= ovf_set || (ovf_reg && !clr_ovf);
         cfa_reg <= match_a || (cfa_reg && !clr_cfa);
         cfb_reg <= match_b || (cfb_reg && !clr_cfb);
      end
   end

   // pin override; direction always stays with the port
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pad_a_reg <= '0;
         pad_b_reg <= '0;
      end
      else
      begin
         pad_a_reg.pin_out <= pin_fn(ctrl_reg.output_action_a, wave_a_next,
                                     port_a.port_data);
         pad_b_reg.pin_out <= pin_fn(ctrl_reg.output_action_b, wave_b_next,
                                     port_b.port_data);
         pad_a_reg.pin_oe  <= port_a.port_dir;
         pad_b_reg.pin_oe  <= port_b.port_dir;
      end
   end

   // outputs
   assign hrdata         = hrdata_reg;
   assign hreadyout      = 1'b1;
   assign hresp          = HRESP_OKAY;
   assign pad_a          = pad_a_reg;
   assign pad_b          = pad_b_reg;
   assign overflow_flag  = ovf_reg;
   assign compare_flag_a = cfa_reg;
   assign compare_flag_b = cfb_reg;

endmodule : tcw_timer

// ==== tcw_timer_props.sv ====
// port assertions for the compare waveform timer
`timescale 1ns/10ps
module tcw_timer_props
   import tcw_pkg::*;
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus request
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   // timer side
   input wire logic        tick_en,
   input wire logic [2:0]  service_ack,
   input wire tcw_pin_t    port_a,
   input wire tcw_pin_t    port_b,
   input wire tcw_pad_t    pad_a,
   input wire tcw_pad_t    pad_b,
   input wire logic        overflow_flag,
   input wire logic        compare_flag_a,
   input wire logic        compare_flag_b
);
   // a flags write in its data phase is the only bus path allowed to drop a flag
   logic flag_wr_reg;
   wire  flag_wr_next = hsel && hready && htrans[HTRANS_ACT_BIT] && hwrite && haddr[7:0] == REG_FLAGS;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_wr_reg <= 1'h0;
      else
         flag_wr_reg <= flag_wr_next;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_oe_a;
      hresetn |=> pad_a.pin_oe == $past(port_a.port_dir);
   endproperty
   a_oe_a: assert property (p_oe_a) else $error("pad a enable off port direction");
   property p_oe_b;
      hresetn |=> pad_b.pin_oe == $past(port_b.port_dir);
   endproperty
   a_oe_b: assert property (p_oe_b) else $error("pad b enable off port direction");
   property p_ovf_hold;
      overflow_flag && !service_ack[0] && !flag_wr_reg |=> overflow_flag;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
   property p_cmpa_hold;
      compare_flag_a && !service_ack[1] && !flag_wr_reg |=> compare_flag_a;
   endproperty
   a_cmpa_hold: assert property (p_cmpa_hold) else $error("compare flag a dropped");
   property p_cmpb_hold;
      compare_flag_b && !service_ack[2] && !flag_wr_reg |=> compare_flag_b;
   endproperty
   a_cmpb_hold: assert property (p_cmpb_hold) else $error("compare flag b dropped");
   property p_ovf_tick;
      $rose(overflow_flag) |-> $past(tick_en);
   endproperty
   a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without tick");
   property p_cmpa_tick;
      $rose(compare_flag_a) |-> $past(tick_en);
   endproperty
   a_cmpa_tick: assert property (p_cmpa_tick) else $error("compare a without tick");
   property p_cmpb_tick;
      $rose(compare_flag_b) |-> $past(tick_en);
   endproperty
   a_cmpb_tick: assert property (p_cmpb_tick) else $error("compare b without tick");
endmodule : tcw_timer_props

bind tcw_timer tcw_timer_props props_u
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .tick_en(tick_en), .service_ack(service_ack),
   .port_a(port_a), .port_b(port_b), .pad_a(pad_a), .pad_b(pad_b),
   .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b)
);

// ==== tcw_port_model.sv ====
// port pin logic model facing the timer pads
`timescale 1ns/10ps
module tcw_port_model
   import tcw_pkg::*;
(
   // clock and software port settings
   input wire logic       hclk,
   input wire logic [1:0] dir_set,
   input wire logic [1:0] data_set,
   // toward the timer
   output tcw_pin_t       port_a,
   output tcw_pin_t       port_b,
   // pads and resolved pins
   input wire tcw_pad_t   pad_a,
   input wire tcw_pad_t   pad_b,
   output logic           pin_a,
   output logic           pin_b
);
   // no pull on these pins, so an undriven pin shows the inverse of its last level
   logic last_a = 1'h0;
   logic last_b = 1'h0;
   assign port_a = {data_set[0], dir_set[0]};
   assign port_b = {data_set[1], dir_set[1]};
   always @(posedge hclk)
   begin
      last_a <= pin_a;
      last_b <= pin_b;
   end
   assign pin_a = pad_a.pin_oe ? pad_a.pin_out : ~last_a;
   assign pin_b = pad_b.pin_oe ? pad_b.pin_out : ~last_b;
endmodule : tcw_port_model

// ==== tb_top.sv ====
// self-checking bench for the compare waveform timer
`timescale 1ns/10ps
module tb_top
   import tcw_pkg::*;
();
   logic        hclk = 1'h0;
   logic        hresetn = 1'h0;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic        tick_en = 1'h0;
   logic [2:0]  service_ack = 3'h0;
   logic [1:0]  dir_set = 2'h3;
   logic [1:0]  data_set = 2'h0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, pin_a, pin_b, overflow_flag, compare_flag_a, compare_flag_b;
   wire tcw_pin_t port_a, port_b;
   wire tcw_pad_t pad_a, pad_b;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;
   logic [7:0]  addrs [5] = '{REG_CTRL, REG_COUNT, REG_FLAGS, REG_STATUS, 8'h1C};
   logic [1:0]  acts [2] = '{ACT_CLEAR, ACT_SET};
   logic [7:0]  cmps [3];

   tcw_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tick_en(tick_en), .service_ack(service_ack),
      .port_a(port_a), .port_b(port_b), .pad_a(pad_a), .pad_b(pad_b), .overflow_flag(overflow_flag),
      .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b));
   tcw_port_model port_u (.hclk(hclk), .dir_set(dir_set), .data_set(data_set), .port_a(port_a),
      .port_b(port_b), .pad_a(pad_a), .pad_b(pad_b), .pin_a(pin_a), .pin_b(pin_b));

   initial
      forever #10 hclk = ~hclk;

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {31'h0, exp}, {31'h0, got});
   endtask : chk_bit

   task automatic step;
      @(posedge hclk);
      #1;
   endtask : step

   // single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask : bus

   // one timer tick when ack is zero, otherwise one service pulse
   task automatic pulse(input logic [2:0] ack);
      @(posedge hclk);
      if (ack == 3'h0)
         tick_en <= 1'h1;
      else
         service_ack <= ack;
      @(posedge hclk);
      tick_en <= 1'h0;
      service_ack <= 3'h0;
      #1;
   endtask : pulse

   function automatic logic [31:0] ctrl(input logic [1:0] a, input logic [1:0] b, input logic [2:0] m);
      return {24'h0, a, b, 1'h0, m};
   endfunction : ctrl

   function automatic int exp_high(input logic [7:0] r, input logic [1:0] act);
      if (r == COUNT_MAX)
         return (act == ACT_CLEAR) ? 256 : 0;
      return (act == ACT_CLEAR) ? r + 1 : 255 - r;
   endfunction : exp_high

   // settle long enough for a wrap and a buffered copy at top
   task automatic setup(input logic [1:0] a, input logic [1:0] b, input logic [2:0] m, input logic [7:0] c);
      logic [31:0] q;
      bus(1'h1, REG_CMP_A, {24'h0, c}, q);
      bus(1'h1, REG_CTRL, ctrl(a, b, m), q);
      repeat (300) step();
   endtask : setup

   // one full 256-cycle period of pin a: high cycles, toggles, first toggle gap
   task automatic watch(output int hi, output int tg, output int gap);
      logic p;
      int f;
      hi = 0;
      tg = 0;
      gap = 0;
      f = 0;
      step();
      p = pin_a;
      for (int i = 1; i <= 256; i++)
      begin
         step();
         hi += (pin_a === 1'h1);
         if (pin_a !== p)
            tg++;
         if (pin_a !== p && tg == 1)
            f = i;
         if (pin_a !== p && tg == 2)
            gap = i - f;
         p = pin_a;
      end
   endtask : watch

   initial
   begin
      logic [31:0] rd;
      logic [7:0] r;
      int hi, tg, gap;
      void'($urandom(32'h3196));
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      foreach (addrs[k])
      begin
         bus(1'h0, addrs[k], WORD_ZERO, rd);
         chk_word("reset read", WORD_ZERO, rd);
         chk_bit("bus response", HRESP_OKAY, hresp);
      end
      bus(1'h1, REG_COUNT, 32'h0000_00FF, rd);
      repeat (5) step();
      bus(1'h0, REG_COUNT, WORD_ZERO, rd);
      chk_word("count held", 32'h0000_00FF, rd);
      pulse(3'h0);
      chk_bit("overflow", 1'h1, overflow_flag);
      bus(1'h0, REG_COUNT, WORD_ZERO, rd);
      chk_word("count wrap", WORD_ZERO, rd);
      pulse(3'h1);
      chk_bit("overflow serviced", 1'h0, overflow_flag);
      pulse(3'h0);
      chk_bit("compare a", 1'h1, compare_flag_a);
      chk_bit("compare b", 1'h1, compare_flag_b);
      bus(1'h1, REG_FLAGS, 32'h0000_0007, rd);
      bus(1'h1, REG_COUNT, WORD_ZERO, rd);
      pulse(3'h0);
      chk_word("flags", WORD_ZERO, {29'h0, compare_flag_b, compare_flag_a, overflow_flag});
      @(posedge hclk);
      data_set <= 2'($urandom);
      repeat (3) step();
      chk_bit("pin a port data", data_set[0], pin_a);
      @(posedge hclk);
      dir_set <= 2'h2;
      repeat (3) step();
      chk_bit("pin a enable", 1'h0, pad_a.pin_oe);
      @(posedge hclk);
      dir_set <= 2'h3;
      bus(1'h1, REG_CTRL, ctrl(ACT_SET, ACT_CLEAR, MODE_NORMAL), rd);
      bus(1'h1, REG_FORCE, 32'h0000_0003, rd);
      bus(1'h0, REG_STATUS, WORD_ZERO, rd);
      chk_word("forced states", 32'h0000_0001, rd & 32'h0000_0003);
      chk_bit("pin a forced", 1'h1, pin_a);
      chk_bit("forced flag", 1'h0, compare_flag_a);
      bus(1'h0, REG_COUNT, WORD_ZERO, rd);
      chk_word("count kept", 32'h0000_0001, rd);
      bus(1'h1, REG_CTRL, ctrl(ACT_TOGGLE, ACT_CLEAR, MODE_FAST_MAX), rd);
      bus(1'h1, REG_FORCE, 32'h0000_0001, rd);
      bus(1'h1, REG_CTRL, ctrl(ACT_TOGGLE, ACT_CLEAR, MODE_NORMAL), rd);
      bus(1'h0, REG_STATUS, WORD_ZERO, rd);
      chk_word("pwm force ignored", 32'h0000_0001, rd & 32'h0000_0003);
      bus(1'h1, REG_FORCE, 32'h0000_0001, rd);
      bus(1'h0, REG_STATUS, WORD_ZERO, rd);
      chk_word("forced toggle", WORD_ZERO, rd & 32'h0000_0003);
      @(posedge hclk);
      tick_en <= 1'h1;
      r = 8'(1 + $urandom % 10);
      setup(ACT_TOGGLE, ACT_OFF, MODE_CLEAR, r);
      watch(hi, tg, gap);
      chk_word("clear mode period", 32'(r) + 1, gap);
      bus(1'h1, REG_COUNT, 32'h0000_0080, rd);
      bus(1'h1, REG_FLAGS, 32'h0000_0007, rd);
      repeat (100) step();
      chk_bit("no match above compare", 1'h0, compare_flag_a);
      chk_bit("no wrap yet", 1'h0, overflow_flag);
      repeat (40) step();
      chk_bit("clear mode overflow", 1'h1, overflow_flag);
      chk_bit("match after wrap", 1'h1, compare_flag_a);
      chk_bit("pin b port data", data_set[1], pin_b);
      cmps = '{8'h00, 8'(1 + $urandom % 254), 8'hFF};
      foreach (cmps[i])
         foreach (acts[j])
         begin
            setup(acts[j], ACT_OFF, MODE_FAST_MAX, cmps[i]);
            bus(1'h1, REG_FLAGS, 32'h0000_0007, rd);
            watch(hi, tg, gap);
            chk_word("fast high cycles", exp_high(cmps[i], acts[j]), hi);
            chk_bit("fast overflow", 1'h1, overflow_flag);
         end
      setup(ACT_TOGGLE, ACT_OFF, MODE_FAST_MAX, r);
      watch(hi, tg, gap);
      chk_word("toggle needs bit2", WORD_ZERO, tg);
      setup(ACT_TOGGLE, ACT_TOGGLE, MODE_FAST_CMP, r);
      watch(hi, tg, gap);
      chk_word("top a toggle period", 32'(r) + 1, gap);
      give_verdict();
   end
endmodule : tb_top
